/* hw/ivp_regs.svh */
// Constants of the interrupt vector, priority and low-voltage block
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// ****************************************************************
// Vector table geometry
// ****************************************************************
`define IVP_VEC_TOP       16'hFFFE  // High byte address of vector 0
`define IVP_VEC_COUNT     32        // Vector numbers 0..31
`define IVP_VEC_RESET     5'h00     // Reset and its shared causes
`define IVP_VEC_SWI       5'h01     // Software interrupt instruction
`define IVP_SRC_COUNT     27        // Flag-and-enable pairs served

// Vector number of each source, index 0 first:
// 0 warn; 1,2 first timer ch0/ch1; 3 first timer ovf; 4..6 second
// timer ch0/ch1/ovf; 7..9 SPI done/fault/empty; 10..13 serial
// errors; 14..17 serial receive; 18,19 serial transmit; 20,21 ports
// A/B; 22 ADC; 23 IIC; 24 real-time; 25 modulo timer; 26 comparator
`define IVP_SRC_VECTORS '{5'h03, 5'h05, 5'h06, 5'h0B, 5'h0C, \
  5'h0D, 5'h0E, 5'h0F, 5'h0F, 5'h0F, 5'h10, 5'h10, 5'h10, 5'h10, \
  5'h11, 5'h11, 5'h11, 5'h11, 5'h12, 5'h12, 5'h14, 5'h15, 5'h17, \
  5'h18, 5'h19, 5'h1A, 5'h1E}
`define IVP_SRC_WARN      0         // Source index of warning flag

// ****************************************************************
// Interrupt entry sequence
// ****************************************************************
`define IVP_STACK_BYTES   3'h5      // Low PC, high PC, X, A, codes
`define IVP_STACK_LAST    3'h4      // Index of the last stacked byte
`define IVP_RST_CLEAR     6'h00     // Status with no reset cause

`endif

/* hw/ivp_pkg.sv */
// Types of the interrupt vector, priority and low-voltage block
package ivp_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    IVP_ST_RESET  = 3'b000,  // Held in reset
    IVP_ST_RUN    = 3'b001,  // Core executing
    IVP_ST_STACK  = 3'b010,  // Registers going to the stack
    IVP_ST_VEC_HI = 3'b011,  // Reading the high vector byte
    IVP_ST_VEC_LO = 3'b100,  // Reading the low vector byte
    IVP_ST_JUMP   = 3'b101   // Service address complete
  } ivp_state_type;

  // Low-voltage control bits
  typedef struct packed {
    logic detectEnable;      // Detector on
    logic stopEnable;        // Detector kept on in stop
    logic resetEnable;       // Low voltage resets the chip
    logic thresholdSelect;   // Trip point choice
    logic warnIrqEnable;     // Warning raises a request
  } ivp_lowvolt_ctrl_type;

  // Reset cause status, most significant first
  typedef struct packed {
    logic powerOn;
    logic extPin;
    logic watchdog;
    logic illegalOp;
    logic illegalAddr;
    logic lowVolt;
  } ivp_rststat_type;

endpackage

/* hw/ivp_top.sv */
// Interrupt vector priority controller with low-voltage control logic
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_top
  import ivp_pkg::*;
#(
  parameter int NSRC = `IVP_SRC_COUNT  // Flag-and-enable pairs
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic [NSRC-1:0]      srcEvent,
  input  wire logic [NSRC-1:0]      srcClear,
  input  wire logic [NSRC-1:0]      srcEnable,
  input  wire logic                 instrBoundary,
  input  wire logic                 swiExecute,
  input  wire logic                 maskSet,
  input  wire logic                 maskClear,
  input  wire logic [7:0]           vecData,
  input  wire logic                 watchdogTimeout,
  input  wire logic                 illegalOpcode,
  input  wire logic                 illegalAddress,
  input  wire logic                 resetPinN,
  input  wire logic                 powerOnDetect,
  input  wire logic                 lowvoltTrip,
  input  wire logic                 lowvoltWarnTrip,
  input  wire ivp_lowvolt_ctrl_type lowvoltCtrl,
  input  wire logic                 stopRequest,
  input  wire logic                 deepStopRequest,
  output logic [NSRC-1:0]           srcFlag,
  output logic                      irqRequest,
  output logic                      globalMask,
  output logic                      stackWrite,
  output logic [2:0]                stackSelect,
  output logic                      vecRead,
  output logic [15:0]               vecAddr,
  output logic                      jumpValid,
  output logic [15:0]               jumpAddr,
  output logic                      chipReset,
  output ivp_rststat_type           resetStatus,
  output logic                      lowvoltActive,
  output logic                      lowvoltThresholdSel,
  output logic                      stopGrant,
  output logic                      deepStopGrant
);

  // ****************************************************************
  // Source to vector map and decoding helpers
  // ****************************************************************
  localparam logic [4:0] SrcVec [NSRC] = `IVP_SRC_VECTORS;

  // High byte address of a vector; the low byte sits one above
  function automatic logic [15:0] vecHiAddr(input logic [4:0] num);
    vecHiAddr = `IVP_VEC_TOP - {10'h000, num, 1'b0};
  endfunction

  // Lowest numbered set bit wins; scanning downward lets it overwrite
  function automatic logic [4:0] topVector(input logic [31:0] req);
    topVector = `IVP_VEC_RESET;
    for (int v = `IVP_VEC_COUNT - 1; v >= 0; v--) begin
      if (req[v]) begin
        topVector = 5'(v);
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Analog and pin levels are asynchronous to the bus clock
  logic [3:0] syncA_q;   // First stage, read only by second stage
  logic [3:0] syncB_q;   // Second stage, safe to use
  logic       lvTrip;    // Supply below the reset threshold
  logic       lvWarn;    // Supply below the warning threshold
  logic       porSeen;   // Power-on detector firing
  logic       pinReset;  // External reset pin asserted

  // Two flops per asynchronous input
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
    end else begin
      syncA_q <= {lowvoltTrip, lowvoltWarnTrip, powerOnDetect, ~resetPinN};
      syncB_q <= syncA_q;
    end
  end
  assign lvTrip   = syncB_q[3];
  assign lvWarn   = syncB_q[2];
  assign porSeen  = syncB_q[1];
  assign pinReset = syncB_q[0];

  // ****************************************************************
  // Low-voltage control and stop gating
  // ****************************************************************
  logic lvOn;  // Detector effectively powered

  // Stop switches the detector off unless stop-enable is set
  assign lvOn = lowvoltCtrl.detectEnable
              & (~stopGrant | lowvoltCtrl.stopEnable);

  // Registered stop handshake and detector state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lowvoltActive       <= 1'b0;
      lowvoltThresholdSel <= 1'b0;
      stopGrant           <= 1'b0;
      deepStopGrant       <= 1'b0;
    end else begin
      lowvoltActive       <= lvOn;
      lowvoltThresholdSel <= lowvoltCtrl.thresholdSelect;
      stopGrant           <= stopRequest;
      // Deep stop would power the detector down, so it is refused while detect enable and stop enable are both set
      deepStopGrant <= stopRequest & deepStopRequest
                     & ~(lowvoltCtrl.detectEnable
                         & lowvoltCtrl.stopEnable);
    end
  end

  // ****************************************************************
  // Reset causes, hold and status
  // ****************************************************************
  logic lvReset;     // Low-voltage reset cause
  logic anyCause;    // Any vector zero cause this cycle
  logic porHold_q;   // Power-on waiting for supply recovery

  assign lvReset  = lowvoltCtrl.resetEnable & lvOn & lvTrip;
  assign anyCause = watchdogTimeout | illegalOpcode | illegalAddress
                  | pinReset | porSeen | lvReset;

  // Power-on hold lasts until the supply is back above threshold
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      porHold_q <= 1'b0;
    end else if (porSeen) begin
      porHold_q <= 1'b1;
    end else if (!lvTrip) begin
      porHold_q <= 1'b0;
    end
  end

  // Chip reset stands while a cause persists, or a low supply after a power-on or low-voltage reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chipReset <= 1'b0;
    end else begin
      chipReset <= anyCause | porHold_q
                 | (chipReset & resetStatus.lowVolt & lvTrip);
    end
  end

  // Status catches the causes active at reset entry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      resetStatus <= `IVP_RST_CLEAR;
    end else if (anyCause && !chipReset) begin
      resetStatus.powerOn     <= porSeen;
      resetStatus.extPin      <= pinReset;
      resetStatus.watchdog    <= watchdogTimeout;
      resetStatus.illegalOp   <= illegalOpcode;
      resetStatus.illegalAddr <= illegalAddress;
      resetStatus.lowVolt     <= porSeen | lvReset;
    end else if (porSeen) begin
      // Power-on during a reset still marks both bits
      resetStatus.powerOn <= 1'b1;
      resetStatus.lowVolt <= 1'b1;
    end
  end

  // ****************************************************************
  // Source flags
  // ****************************************************************
  logic [NSRC-1:0] setEvent;  // Event per source, warning included

  // Warning is detected internally while the detector is on
  always_comb begin
    setEvent = srcEvent;
    setEvent[`IVP_SRC_WARN] = lvWarn & lvOn;
  end

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      srcFlag <= '0;
    end else begin
      srcFlag <= (srcFlag & ~srcClear) | setEvent;
    end
  end

  // ****************************************************************
  // Vector requests and priority
  // ****************************************************************
  logic [31:0] vecReq;   // Request per vector number
  logic [4:0]  winner;   // Highest priority pending vector
  logic        anyReq;   // Any maskable request present

  // Each used vector ORs its flag-and-enable pairs
  always_comb begin
    vecReq = 32'h0000_0000;
    for (int s = 0; s < NSRC; s++) begin
      if (srcFlag[s] && srcEnable[s]) begin
        vecReq[SrcVec[s]] = 1'b1;
      end
    end
  end
  assign anyReq = |vecReq;
  assign winner = topVector(vecReq);

  // Request line towards the core, blocked by the global mask
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= anyReq & ~globalMask;
    end
  end

  // ****************************************************************
  // Entry sequencer
  // ****************************************************************
  ivp_state_type state_q;     // Sequencer state
  logic [2:0]    stackIdx_q;  // Byte being stacked
  logic [4:0]    vecNum_q;    // Vector being fetched
  logic          takeIrq;     // Start an entry sequence

  // Software interrupt beats every maskable source; reset beats all
  assign takeIrq = instrBoundary & (swiExecute | (anyReq & ~globalMask));

  // State, vector choice and stacking count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q    <= IVP_ST_RESET;
      stackIdx_q <= 3'h0;
      vecNum_q   <= `IVP_VEC_RESET;
    end else if (chipReset) begin
      state_q  <= IVP_ST_RESET;
      vecNum_q <= `IVP_VEC_RESET;
    end else begin
      case (state_q)
        IVP_ST_RESET: begin
          // Reset entry fetches vector zero without stacking
          state_q  <= IVP_ST_VEC_HI;
          vecNum_q <= `IVP_VEC_RESET;
        end
        IVP_ST_RUN: begin
          if (takeIrq) begin
            state_q    <= IVP_ST_STACK;
            stackIdx_q <= 3'h0;
            vecNum_q   <= swiExecute ? `IVP_VEC_SWI : winner;
          end
        end
        IVP_ST_STACK: begin
          if (stackIdx_q == `IVP_STACK_LAST) begin
            state_q <= IVP_ST_VEC_HI;
          end
          stackIdx_q <= stackIdx_q + 3'h1;
        end
        IVP_ST_VEC_HI: state_q <= IVP_ST_VEC_LO;
        IVP_ST_VEC_LO: state_q <= IVP_ST_JUMP;
        IVP_ST_JUMP:   state_q <= IVP_ST_RUN;
        default:       state_q <= IVP_ST_RESET;
      endcase
    end
  end

  // Global mask: set by reset and by every entry, else core controls
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      globalMask <= 1'b1;
    end else if (chipReset || state_q == IVP_ST_VEC_HI) begin
      globalMask <= 1'b1;
    end else if (maskSet) begin
      globalMask <= 1'b1;
    end else if (maskClear) begin
      globalMask <= 1'b0;
    end
  end

  // Stack and vector fetch strobes; read data returns in the strobe cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stackWrite  <= 1'b0;
      stackSelect <= 3'h0;
      vecRead     <= 1'b0;
      vecAddr     <= 16'h0000;
      jumpValid   <= 1'b0;
      jumpAddr    <= 16'h0000;
    end else begin
      // Select 0..4: low PC, high PC, X, A, condition codes
      stackWrite  <= (state_q == IVP_ST_STACK) && !chipReset;
      stackSelect <= stackIdx_q;
      vecRead     <= ((state_q == IVP_ST_VEC_HI) || (state_q == IVP_ST_VEC_LO))
                     && !chipReset;
      if (state_q == IVP_ST_VEC_HI) begin
        vecAddr <= vecHiAddr(vecNum_q);
      end else if (state_q == IVP_ST_VEC_LO) begin
        vecAddr <= vecHiAddr(vecNum_q) + 16'h0001;
      end
      jumpValid <= (state_q == IVP_ST_JUMP) && !chipReset;
      if (state_q == IVP_ST_VEC_LO) begin
        jumpAddr[15:8] <= vecData;
      end else if (state_q == IVP_ST_JUMP) begin
        jumpAddr[7:0] <= vecData;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_mask_reset: assert property (@(posedge clock) $rose(rstn) |-> globalMask)
    else $error("mask not set after reset");

  chk_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
    (srcFlag[1] && !srcClear[1]) |=> srcFlag[1])
    else $error("flag dropped without clear");

  chk_set_wins: assert property (@(posedge clock) disable iff (!rstn)
    srcEvent[2] |=> srcFlag[2])
    else $error("event did not set flag");

  chk_irq_gate: assert property (@(posedge clock) disable iff (!rstn)
    irqRequest |-> $past(anyReq) && !$past(globalMask))
    else $error("request without enabled flag");

  chk_stack_five: assert property (@(posedge clock) disable iff (!rstn || chipReset)
    (state_q == IVP_ST_RUN && takeIrq) |=> ##1 stackWrite[*5] ##1 !stackWrite)
    else $error("stack sequence not five bytes");

  chk_vec_pair: assert property (@(posedge clock) disable iff (!rstn || chipReset)
    (vecRead && state_q == IVP_ST_VEC_LO) |=> vecAddr == $past(vecAddr) + 16'h0001)
    else $error("low vector byte not above high");

  chk_swi_vector: assert property (@(posedge clock) disable iff (!rstn || chipReset)
    (state_q == IVP_ST_RUN && instrBoundary && swiExecute)
      |=> vecNum_q == `IVP_VEC_SWI)
    else $error("software interrupt took wrong vector");

  chk_priority_low: assert property (@(posedge clock) disable iff (!rstn)
    (vecReq[5] && vecReq[6]) |-> winner <= 5'h05)
    else $error("lower vector did not win");

  chk_unused_idle: assert property (@(posedge clock) disable iff (!rstn)
    !vecReq[2] && !vecReq[4] && !vecReq[31] && !vecReq[0])
    else $error("unassigned vector pending");

  chk_deep_refuse: assert property (@(posedge clock) disable iff (!rstn)
    (lowvoltCtrl.detectEnable && lowvoltCtrl.stopEnable) |=> !deepStopGrant)
    else $error("deep stop granted with detector kept on");

  chk_lv_reset: assert property (@(posedge clock) disable iff (!rstn)
    lvReset |=> chipReset && resetStatus.lowVolt)
    else $error("low-voltage reset not taken");

  chk_por_hold: assert property (@(posedge clock) disable iff (!rstn)
    (porHold_q && lvTrip) |=> chipReset)
    else $error("power-on released before recovery");

  chk_warn_flag: assert property (@(posedge clock) disable iff (!rstn)
    (lvWarn && lvOn) |=> srcFlag[`IVP_SRC_WARN])
    else $error("warning flag not set");

endmodule

/* dv/ivp_cpu_model.sv */
// CPU core partner: instruction boundaries and vector memory
`timescale 1ns/1ps
module ivp_cpu_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        vecRead,
  input  wire logic [15:0] vecAddr,
  output logic             instrBoundary,
  output logic [7:0]       vecData
);
  // Memory byte at an address, distinct for every vector byte
  function automatic logic [7:0] memByte(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // Boundary each cycle, or now and then to stretch instructions
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      instrBoundary <= 1'h0;
    end else begin
      instrBoundary <= !slow || ($urandom % 3 == 0);
    end
  end

  logic [7:0] idleData_q;  // Toggling idle bus value

  // Idle bus toggles so a mistimed capture never sees a stale byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idleData_q <= 8'h00;
    end else begin
      idleData_q <= ~idleData_q;
    end
  end

  // Byte stands while the strobe stands; the block takes it at the
  // edge that ends the strobe cycle
  assign vecData = vecRead ? memByte(vecAddr) : idleData_q;
endmodule

/* dv/ivp_top_tb.sv */
// Self-checking bench of the interrupt vector and low-voltage block
`timescale 1ns/1ps
module ivp_top_tb;
  import ivp_pkg::*;
  // ************************************************
  // Signals
  // ************************************************
  localparam int N = 27;
  logic                 clock = 1'h0;
  logic                 rstn = 1'h0;
  logic                 slow = 1'h0;
  logic [N-1:0]         srcEvent = '0, srcClear = '0, srcEnable = '0;
  logic                 swiExecute = 1'h0, maskSet = 1'h0, maskClear = 1'h0;
  logic                 watchdogTimeout = 1'h0, illegalOpcode = 1'h0;
  logic                 illegalAddress = 1'h0, resetPinN = 1'h1;
  logic                 powerOnDetect = 1'h0, lowvoltTrip = 1'h0;
  logic                 lowvoltWarnTrip = 1'h0;
  logic                 stopRequest = 1'h0, deepStopRequest = 1'h0;
  ivp_lowvolt_ctrl_type lowvoltCtrl = '0;
  logic [N-1:0]         srcFlag;
  logic                 irqRequest, globalMask, stackWrite, vecRead, jumpValid;
  logic [2:0]           stackSelect;
  logic [15:0]          vecAddr, jumpAddr;
  logic                 chipReset, lowvoltActive, lowvoltThresholdSel;
  logic                 stopGrant, deepStopGrant, instrBoundary;
  logic [7:0]           vecData;
  ivp_rststat_type      resetStatus;
  int                   n_fail = 0, n_compared = 0;
  // Vector number of each source index
  int vt[N] = '{3, 5, 6, 11, 12, 13, 14, 15, 15, 15, 16, 16, 16, 16,
                17, 17, 17, 17, 18, 18, 20, 21, 23, 24, 25, 26, 30};

  always #4 clock = ~clock;

  ivp_top i_ivp_top (
    .clock(clock), .rstn(rstn), .srcEvent(srcEvent), .srcClear(srcClear),
    .srcEnable({srcEnable[N-1:1], lowvoltCtrl.warnIrqEnable}),
    .instrBoundary(instrBoundary), .swiExecute(swiExecute), .maskSet(maskSet),
    .maskClear(maskClear), .vecData(vecData), .watchdogTimeout(watchdogTimeout),
    .illegalOpcode(illegalOpcode), .illegalAddress(illegalAddress),
    .resetPinN(resetPinN), .powerOnDetect(powerOnDetect), .lowvoltTrip(lowvoltTrip),
    .lowvoltWarnTrip(lowvoltWarnTrip), .lowvoltCtrl(lowvoltCtrl),
    .stopRequest(stopRequest), .deepStopRequest(deepStopRequest), .srcFlag(srcFlag),
    .irqRequest(irqRequest), .globalMask(globalMask), .stackWrite(stackWrite),
    .stackSelect(stackSelect), .vecRead(vecRead), .vecAddr(vecAddr),
    .jumpValid(jumpValid), .jumpAddr(jumpAddr), .chipReset(chipReset),
    .resetStatus(resetStatus), .lowvoltActive(lowvoltActive),
    .lowvoltThresholdSel(lowvoltThresholdSel), .stopGrant(stopGrant),
    .deepStopGrant(deepStopGrant));

  ivp_cpu_model i_ivp_cpu_model (
    .clock(clock), .rstn(rstn), .slow(slow), .vecRead(vecRead), .vecAddr(vecAddr),
    .instrBoundary(instrBoundary), .vecData(vecData));

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Service address that the partner memory holds for vector n
  function automatic logic [15:0] expJ(input int n);
    logic [7:0] a;
    a = 8'hFE - 8'(2 * n);
    return {a ^ 8'h5A, (a + 8'h01) ^ 8'h5A};
  endfunction

  // Event and clear pulses, then settle; also ends a mask clear
  task automatic ev(input logic [N-1:0] e, input logic [N-1:0] c);
    @(posedge clock);
    srcEvent <= e;
    srcClear <= c;
    @(posedge clock);
    srcEvent <= '0;
    srcClear <= '0;
    maskClear <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Wait for one entry; vector 0 has no stacking
  task automatic take(input int n);
    int k, s;
    s = 0;
    @(posedge clock);
    maskClear <= (n > 1);
    for (k = 0; k < 80; k++) begin
      @(posedge clock);
      maskClear <= 1'h0;
      if (s > 0) swiExecute <= 1'h0;
      #1;
      if (stackWrite === 1'h1) begin
        chk(16'(stackSelect), 16'(s));
        s++;
      end
      if (jumpValid === 1'h1) break;
    end
    chk(16'(jumpValid), 16'h1);
    chk(jumpAddr, expJ(n));
    chk(16'(s), (n != 0) ? 16'h5 : 16'h0);
    chk(16'(globalMask), 16'h1);
  endtask

  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    give_verdict();
  end

  // ************************************************
  // Scenarios
  // ************************************************
  initial begin
    int i, j, k, m;
    k = $urandom(75422);
    repeat (5) @(posedge clock);
    #1;
    chk(16'(globalMask), 16'h1);
    @(posedge clock);
    rstn <= 1'h1;
    take(0);
    // Each source from index 1 alone: sticky while disabled, then its own vector
    for (i = 1; i < N; i++) begin
      @(posedge clock);
      slow <= i[0];
      srcEnable <= '0;
      maskClear <= 1'h1;
      ev(N'(1) << i, '0);
      chk(16'(srcFlag[i]), 16'h1);
      chk(16'(irqRequest), 16'h0);
      @(posedge clock);
      srcEnable <= N'(1) << i;
      take(vt[i]);
      ev('0, N'(1) << i);
      chk(16'(srcFlag[i]), 16'h0);
    end
    // Random pairs: the lower vector number wins
    for (m = 0; m < 12; m++) begin
      i = 1 + $urandom % (N - 1);
      j = 1 + $urandom % (N - 1);
      @(posedge clock);
      slow <= $urandom % 2;
      srcEnable <= N'($urandom) | (N'(1) << i) | (N'(1) << j);
      ev((N'(1) << i) | (N'(1) << j), '0);
      take((vt[i] < vt[j]) ? vt[i] : vt[j]);
      ev('0, (N'(1) << i) | (N'(1) << j));
    end
    // Software interrupt beats a pending comparator request
    @(posedge clock);
    srcEnable <= N'(1) << 26;
    ev(N'(1) << 26, '0);
    @(posedge clock);
    swiExecute <= 1'h1;
    take(1);
    take(30);
    ev('0, N'(1) << 26);
    // Warning flag and its request
    @(posedge clock);
    lowvoltCtrl <= ivp_lowvolt_ctrl_type'(5'h11);
    lowvoltWarnTrip <= 1'h1;
    repeat (4) @(posedge clock);
    lowvoltWarnTrip <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    chk(16'(srcFlag[0]), 16'h1);
    take(3);
    ev('0, N'(1));
    // Stop gating over all enable pairs
    for (m = 0; m < 4; m++) begin
      @(posedge clock);
      lowvoltCtrl <= ivp_lowvolt_ctrl_type'({m[1], m[0], 3'h0});
      stopRequest <= 1'h1;
      deepStopRequest <= 1'h1;
      repeat (3) @(posedge clock);
      #1;
      chk(16'(stopGrant), 16'h1);
      chk(16'(deepStopGrant), 16'(m != 3));
      chk(16'(lowvoltActive), 16'(m == 3));
      @(posedge clock);
      stopRequest <= 1'h0;
      deepStopRequest <= 1'h0;
      repeat (3) @(posedge clock);
      #1;
      chk(16'(lowvoltActive), 16'(m[1]));
    end
    // Low-voltage reset held until recovery
    k = $urandom % 2;
    @(posedge clock);
    lowvoltCtrl <= ivp_lowvolt_ctrl_type'({3'h5, k[0], 1'h0});
    repeat (3) @(posedge clock);
    #1;
    chk(16'(lowvoltThresholdSel), 16'(k[0]));
    @(posedge clock);
    lowvoltTrip <= 1'h1;
    repeat (8) @(posedge clock);
    #1;
    chk(16'(chipReset), 16'h1);
    @(posedge clock);
    lowvoltTrip <= 1'h0;
    take(0);
    chk(16'(resetStatus), 16'h01);
    // Pin, watchdog, opcode and address causes share vector 0
    for (m = 0; m < 4; m++) begin
      @(posedge clock);
      resetPinN <= (m != 0);
      watchdogTimeout <= (m == 1);
      illegalOpcode <= (m == 2);
      illegalAddress <= (m == 3);
      repeat (3) @(posedge clock);
      resetPinN <= 1'h1;
      {watchdogTimeout, illegalOpcode, illegalAddress} <= 3'h0;
      take(0);
      chk(16'(resetStatus), 16'h10 >> m);
    end
    // Power-on held in reset by a low supply
    @(posedge clock);
    lowvoltCtrl <= '0;
    powerOnDetect <= 1'h1;
    lowvoltTrip <= 1'h1;
    repeat (3) @(posedge clock);
    powerOnDetect <= 1'h0;
    repeat (8) @(posedge clock);
    #1;
    chk(16'(chipReset), 16'h1);
    @(posedge clock);
    lowvoltTrip <= 1'h0;
    take(0);
    chk(16'(resetStatus), 16'h21);
    give_verdict();
  end
endmodule
